// File: rtl/uft_pkg.sv
// Package with register map, field layout and reset values of the frame timing and root hub block.
package uft_pkg;

	// Register byte offsets on the AHB-Lite port.
	localparam logic [7:0] OFS_INTERVAL   = 8'h00;
	localparam logic [7:0] OFS_TIME_LEFT  = 8'h04;
	localparam logic [7:0] OFS_FRAME_CNT  = 8'h08;
	localparam logic [7:0] OFS_PERIODIC   = 8'h0c;
	localparam logic [7:0] OFS_SLOW_LIMIT = 8'h10;
	localparam logic [7:0] OFS_DESC_A     = 8'h14;
	localparam logic [7:0] OFS_DESC_B     = 8'h18;
	localparam logic [7:0] OFS_HUB_STATE  = 8'h1c;

	// Field positions.
	localparam int TOGGLE_BIT   = 31;
	localparam int POWER_WAIT_LO = 24;
	localparam int NO_OC_BIT    = 12;
	localparam int OC_MODE_BIT  = 11;
	localparam int COMPOUND_BIT = 10;
	localparam int NO_PSW_BIT   = 9;
	localparam int PORT_MODE_BIT = 8;
	localparam int WAKE_CLR_BIT = 31;
	localparam int OC_CHG_BIT   = 17;
	localparam int PWR_SET_BIT  = 16;
	localparam int WAKE_EN_BIT  = 15;
	localparam int OC_FLAG_BIT  = 1;

	// Reset values and fixed values.
	localparam logic [13:0] INTERVAL_RST   = 14'h2edf;
	localparam logic [13:0] SLOW_LIMIT_RST = 14'h0628;
	localparam logic [13:0] PERIODIC_RST   = 14'h0000;
	localparam logic [7:0]  POWER_WAIT_RST = 8'h0a;
	localparam logic [7:0]  PORT_COUNT     = 8'h03;
	localparam logic [3:0]  PORT_BITS_MASK = 4'he;

	// Timebase: the 12 MHz bit tick is made by phase accumulation from the 25 MHz clock.
	localparam int unsigned CLK_HZ  = 25000000;
	localparam int unsigned TICK_HZ = 12000000;
	localparam logic [24:0] TICK_INC = 25'(TICK_HZ / 1000);
	localparam logic [24:0] TICK_MOD = 25'(CLK_HZ / 1000);

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		UFT_RUN     = 3'b001,
		UFT_SUSPEND = 3'b010,
		UFT_RESUME  = 3'b100
	} uft_hub_t;

endpackage

// File: rtl/uft_frame_hub.sv
// Frame timebase, frame counter, scheduling limits and root hub registers behind AHB-Lite.
// Function
// - reload copies interval toggle into left toggle
// - 14-bit bit-time countdown reloaded each frame
// - 16-bit frame count increments on reload, wraps
// - after increment publish count, flag start-of-frame
// - periodic_start marks periodic priority point, resets 0
// - low-speed start only while count above cutoff
// - power_on_wait 8-bit, reset 0xA, inert
// - no_overcurrent_inputs resets one, overcurrent_mode inert
// - compound_flag always reads zero
// - no_power_switch resets one, per_port_power_mode zero
// - port_count always reads three
// - port_power_mask ports 1-3, others reserved
// - device_fixed_bits ports 1-3, reset zero
// - wake_enable_clear write one clears wake enable
// - wake enable lets connect change resume suspend
// - global_power_set powers ports per mode and mask
// - overcurrent_change set on flag change, W1C
// - overcurrent_flag always reads zero
// - interval_length reset 0x2EDF, toggle with changes
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module uft_frame_hub
	import uft_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// AHB-Lite slave.
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Frame events toward the list processor and shared memory writer.
	output logic             frame_start_out,
	output logic      [15:0] frame_count_out,
	output logic             periodic_first_out,
	output logic             slow_start_ok_out,
	// Root hub events.
	input  wire logic        connect_change_in,
	input  wire logic        suspend_req_in,
	input  wire logic        resume_done_in,
	output logic             resume_seen_out,
	output logic             suspended_out,
	output logic      [2:0]  port_power_out
);
	import uft_pkg::*;

	logic [13:0] interval_length;
	logic        interval_toggle;
	logic [13:0] bit_times_left;
	logic        left_count_toggle;
	logic [15:0] frame_count;
	logic [13:0] periodic_start;
	logic [13:0] slow_packet_cutoff;
	logic [7:0]  power_on_wait;
	logic        no_overcurrent_inputs;
	logic        overcurrent_mode;
	logic        no_power_switch;
	logic        per_port_power_mode;
	logic [3:0]  port_power_mask;
	logic [3:0]  device_fixed_bits;
	logic        remote_wake_enable;
	logic        overcurrent_change;
	logic        overcurrent_flag;
	logic        overcurrent_flag_q;
	logic [24:0] tick_acc;
	logic        bit_tick;
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        wr_en;
	uft_hub_t    hub_state;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// The global flag has no input pin on this part.
	// flag tied low
	assign overcurrent_flag = 1'b0;

	// Bus: zero wait states, every access answers OKAY.
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign wr_en         = wr_pend;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else if (hready_in)
		begin
			wr_pend <= hsel_in && htrans_in[1] && hwrite_in;
			wr_addr <= haddr_in[7:0];
		end
	end

	// Read data is registered during the address phase so it stands in the data phase.
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			hrdata_out <= 32'h0;
		else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
		begin
			if (hit(haddr_in[7:0], OFS_INTERVAL))
				hrdata_out <= {interval_toggle, 17'h0, interval_length};
			else if (hit(haddr_in[7:0], OFS_TIME_LEFT))
				hrdata_out <= {left_count_toggle, 17'h0, bit_times_left};
			else if (hit(haddr_in[7:0], OFS_FRAME_CNT))
				hrdata_out <= {16'h0, frame_count};
			else if (hit(haddr_in[7:0], OFS_PERIODIC))
				hrdata_out <= {18'h0, periodic_start};
			else if (hit(haddr_in[7:0], OFS_SLOW_LIMIT))
				hrdata_out <= {18'h0, slow_packet_cutoff};
			else if (hit(haddr_in[7:0], OFS_DESC_A))
				hrdata_out <= {power_on_wait, 11'h0, no_overcurrent_inputs, overcurrent_mode,
					1'b0, no_power_switch, per_port_power_mode, PORT_COUNT};
			else if (hit(haddr_in[7:0], OFS_DESC_B))
				hrdata_out <= {12'h0, port_power_mask, 12'h0, device_fixed_bits};
			else if (hit(haddr_in[7:0], OFS_HUB_STATE))
				hrdata_out <= {14'h0, overcurrent_change, 1'b0, remote_wake_enable, 13'h0,
					overcurrent_flag, 1'b0};
			else
				hrdata_out <= 32'h0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			interval_length <= INTERVAL_RST;
			interval_toggle <= 1'b0;
		end
		else if (wr_en && hit(wr_addr, OFS_INTERVAL))
		begin
			interval_length <= hwdata_in[13:0];
			interval_toggle <= hwdata_in[TOGGLE_BIT];
		end
	end

	// A 12/25 phase accumulator gives the average full-speed bit rate without a second clock.
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			tick_acc <= 25'h0;
			bit_tick <= 1'b0;
		end
		else if (tick_acc + TICK_INC >= TICK_MOD)
		begin
			tick_acc <= tick_acc + TICK_INC - TICK_MOD;
			bit_tick <= 1'b1;
		end
		else
		begin
			tick_acc <= tick_acc + TICK_INC;
			bit_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			bit_times_left    <= 14'h0;
			left_count_toggle <= 1'b0;
		end
		else if (bit_tick)
		begin
			if (bit_times_left == 14'h0)
			begin
				bit_times_left    <= interval_length;
				left_count_toggle <= interval_toggle;
			end
			else
				bit_times_left <= bit_times_left - 14'h1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			frame_count <= 16'h0;
		else if (bit_tick && bit_times_left == 14'h0)
			frame_count <= frame_count + 16'h1;
	end

	// start of frame after increment, with new count published
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			frame_start_out <= 1'b0;
		else
			frame_start_out <= bit_tick && bit_times_left == 14'h0;
	end
	assign frame_count_out = frame_count;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			periodic_start     <= PERIODIC_RST;
			slow_packet_cutoff <= SLOW_LIMIT_RST;
		end
		else if (wr_en && hit(wr_addr, OFS_PERIODIC))
			periodic_start <= hwdata_in[13:0];
		else if (wr_en && hit(wr_addr, OFS_SLOW_LIMIT))
			slow_packet_cutoff <= hwdata_in[13:0];
	end

	// Count runs down, so periodic leads once it falls to periodic_start.
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			periodic_first_out <= 1'b0;
			slow_start_ok_out  <= 1'b0;
		end
		else
		begin
			periodic_first_out <= bit_times_left <= periodic_start;
			slow_start_ok_out  <= bit_times_left > slow_packet_cutoff;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			power_on_wait         <= POWER_WAIT_RST;
			no_overcurrent_inputs <= 1'b1;
			overcurrent_mode      <= 1'b0;
			no_power_switch       <= 1'b1;
			per_port_power_mode   <= 1'b0;
		end
		else if (wr_en && hit(wr_addr, OFS_DESC_A))
		begin
			power_on_wait         <= hwdata_in[31:POWER_WAIT_LO];
			no_overcurrent_inputs <= hwdata_in[NO_OC_BIT];
			overcurrent_mode      <= hwdata_in[OC_MODE_BIT];
			no_power_switch       <= hwdata_in[NO_PSW_BIT];
			per_port_power_mode   <= hwdata_in[PORT_MODE_BIT];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			port_power_mask   <= 4'h0;
			device_fixed_bits <= 4'h0;
		end
		else if (wr_en && hit(wr_addr, OFS_DESC_B))
		begin
			port_power_mask   <= hwdata_in[19:16] & PORT_BITS_MASK;
			device_fixed_bits <= hwdata_in[3:0] & PORT_BITS_MASK;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			remote_wake_enable <= 1'b0;
		else if (wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[WAKE_CLR_BIT])
			remote_wake_enable <= 1'b0;
		else if (wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[WAKE_EN_BIT])
			remote_wake_enable <= 1'b1;
	end

	// change flag, set wins over clear
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			overcurrent_flag_q <= 1'b0;
			overcurrent_change <= 1'b0;
		end
		else
		begin
			overcurrent_flag_q <= overcurrent_flag;
			if (overcurrent_flag != overcurrent_flag_q)
				overcurrent_change <= 1'b1;
			else if (wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[OC_CHG_BIT])
				overcurrent_change <= 1'b0;
		end
	end

	// global power set per mode and mask
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			port_power_out <= 3'h0;
		else if (wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[PWR_SET_BIT])
		begin
			if (!per_port_power_mode)
				port_power_out <= 3'h7;
			else
				port_power_out <= port_power_out | ~port_power_mask[3:1];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			hub_state       <= UFT_RUN;
			resume_seen_out <= 1'b0;
		end
		else
		begin
			resume_seen_out <= 1'b0;
			case (hub_state)
				UFT_RUN:
					if (suspend_req_in)
						hub_state <= UFT_SUSPEND;
				UFT_SUSPEND:
					if (connect_change_in && remote_wake_enable)
					begin
						hub_state       <= UFT_RESUME;
						resume_seen_out <= 1'b1;
					end
				UFT_RESUME:
					if (resume_done_in)
						hub_state <= UFT_RUN;
				default:
					hub_state <= UFT_RUN;
			endcase
		end
	end
	assign suspended_out = (hub_state != UFT_RUN);

	slow_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		slow_start_ok_out |-> $past(bit_times_left) > $past(slow_packet_cutoff))
		else $error("low-speed start allowed at or below cutoff");
	count_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		frame_start_out |-> frame_count == $past(frame_count) + 16'h1)
		else $error("frame count did not step at frame start");
	reload_val_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		frame_start_out |-> bit_times_left == $past(interval_length))
		else $error("countdown not reloaded from interval");
	toggle_copy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		frame_start_out |-> left_count_toggle == $past(interval_toggle))
		else $error("left toggle not copied on reload");
	wake_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		resume_seen_out |-> $past(remote_wake_enable) && hub_state == UFT_RESUME)
		else $error("resume without wake enable");
	// count drops by one on each tick while above zero
	count_down_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$past(bit_tick) && $past(bit_times_left) != 14'h0 |-> bit_times_left == $past(bit_times_left) - 14'h1)
		else $error("countdown did not decrement");
	wake_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[WAKE_CLR_BIT] |=> !remote_wake_enable)
		else $error("wake enable not cleared");
	power_all_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_en && hit(wr_addr, OFS_HUB_STATE) && hwdata_in[PWR_SET_BIT] && !per_port_power_mode
		|=> port_power_out == 3'h7)
		else $error("global power set missed ports");

endmodule

// File: verification/uft_usb_dev_model.sv
// Downstream device model: reports attach events and finishes resume signalling after a delay.
`timescale 1ns/100ps

module uft_usb_dev_model
(
	// Clock and reset.
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// Bench commands.
	input  wire logic       plug_in,
	input  wire logic [3:0] delay_in,
	// Host side.
	input  wire logic       resume_seen_in,
	output logic            connect_change_out,
	output logic            resume_done_out
);
	logic [3:0] plug_wait;
	logic       plug_pend;
	logic [3:0] res_wait;
	logic       res_pend;

	// attach as wake event
	// A slow device reports the attach only after delay_in cycles.
	always_ff @(posedge clk_in)
	begin
		connect_change_out <= 1'b0;
		if (sys_rst_in)
			plug_pend <= 1'b0;
		else if (plug_in)
		begin
			plug_pend <= 1'b1;
			plug_wait <= delay_in;
		end
		else if (plug_pend && plug_wait == 4'h0)
		begin
			plug_pend <= 1'b0;
			connect_change_out <= 1'b1;
		end
		else if (plug_pend)
			plug_wait <= plug_wait - 4'h1;
	end

	always_ff @(posedge clk_in)
	begin
		resume_done_out <= 1'b0;
		if (sys_rst_in)
			res_pend <= 1'b0;
		else if (resume_seen_in)
		begin
			res_pend <= 1'b1;
			res_wait <= delay_in;
		end
		else if (res_pend && res_wait == 4'h0)
		begin
			res_pend <= 1'b0;
			resume_done_out <= 1'b1;
		end
		else if (res_pend)
			res_wait <= res_wait - 4'h1;
	end
endmodule

// File: verification/uft_frame_hub_bench.sv
// Self-checking bench for the frame timing and root hub block.
`timescale 1ns/100ps

module uft_frame_hub_bench;
	import uft_pkg::*;
	logic        clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        susp_req = 1'b0;
	logic        plug = 1'b0;
	logic [3:0]  dly = 4'h0;
	logic [31:0] hrdata;
	logic        ready, hresp, fstart, pfirst, slow_ok, cchg, res_done, res_seen, suspended;
	logic [15:0] fcount;
	logic [2:0]  ppower;
	int          error_cnt = 0;
	int          checked = 0;

	uft_frame_hub dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(ready),
		.hrdata_out(hrdata), .hreadyout_out(ready), .hresp_out(hresp), .frame_start_out(fstart),
		.frame_count_out(fcount), .periodic_first_out(pfirst), .slow_start_ok_out(slow_ok),
		.connect_change_in(cchg), .suspend_req_in(susp_req), .resume_done_in(res_done),
		.resume_seen_out(res_seen), .suspended_out(suspended), .port_power_out(ppower));

	uft_usb_dev_model dev (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .plug_in(plug), .delay_in(dly),
		.resume_seen_in(res_seen), .connect_change_out(cchg), .resume_done_out(res_done));

	always #20 clk_in = ~clk_in;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk_in); while (ready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_in); while (ready !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic watch(input int c, output logic s);
		s = 1'b0;
		repeat (c)
		begin
			@(posedge clk_in);
			if (res_seen === 1'b1)
				s = 1'b1;
		end
	endtask

	task automatic test_reset;
		rd_chk(OFS_INTERVAL, 32'h0000_2edf);
		rd_chk(OFS_PERIODIC, 32'h0);
		rd_chk(OFS_SLOW_LIMIT, 32'h0000_0628);
		rd_chk(OFS_DESC_A, 32'h0a00_1203);
		rd_chk(OFS_DESC_B, 32'h0);
		rd_chk(OFS_HUB_STATE, 32'h0);
		rd_chk(8'h40, 32'h0);
		chk({29'h0, ppower}, 32'h0);
		$display("reset values done");
	endtask

	task automatic test_desc;
		wr(OFS_HUB_STATE, 32'h0001_0000);
		@(posedge clk_in);
		chk({29'h0, ppower}, 32'h7);
		// A reset in mid-run must bring the power status and descriptor A back.
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		chk({29'h0, ppower}, 32'h0);
		rd_chk(OFS_DESC_A, 32'h0a00_1203);
		wr(OFS_DESC_A, 32'hff00_0dff);
		rd_chk(OFS_DESC_A, 32'hff00_0903);
		wr(OFS_DESC_B, 32'hffff_ffff);
		rd_chk(OFS_DESC_B, 32'h000e_000e);
		wr(OFS_DESC_B, 32'h0004_0000);
		wr(8'h40, 32'hffff_ffff);
		rd_chk(8'h40, 32'h0);
		wr(OFS_HUB_STATE, 32'h0001_0000);
		repeat (2) @(posedge clk_in);
		chk({29'h0, ppower}, 32'h5);
		rd_chk(OFS_HUB_STATE, 32'h0);
		$display("descriptor test done");
	endtask

	task automatic test_frame;
		int n;
		logic [15:0] fc;
		logic [31:0] q;
		// Ten percent below an interval of twenty gives periodic priority from eighteen down.
		wr(OFS_PERIODIC, 32'hffff_c012);
		wr(OFS_SLOW_LIMIT, 32'h0000_000a);
		wr(OFS_INTERVAL, 32'h8000_0014);
		rd_chk(OFS_PERIODIC, 32'h12);
		rd_chk(OFS_SLOW_LIMIT, 32'ha);
		n = 0;
		while (fstart !== 1'b1 && n < 30000)
		begin
			@(posedge clk_in);
			n++;
		end
		chk({31'h0, fstart}, 32'h1);
		fc = fcount;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
			if (n == 3)
				chk({30'h0, slow_ok, pfirst}, 32'h2);
			if (n == 36)
				chk({30'h0, slow_ok, pfirst}, 32'h1);
		end
		while (fstart !== 1'b1 && n < 100);
		// Twenty-one bit times at 12 of 25 clocks give about 44 clocks.
		chk({31'h0, n >= 42 && n <= 46}, 32'h1);
		chk({16'h0, fcount}, {16'h0, fc + 16'h1});
		bus(1'b0, OFS_TIME_LEFT, 32'h0, q);
		chk({30'h0, q[31], q[13:0] <= 14'd20}, 32'h3);
		rd_chk(OFS_FRAME_CNT, {16'h0, fc + 16'h1});
		$display("frame test done");
	endtask

	task automatic test_wake;
		logic s;
		@(posedge clk_in);
		susp_req <= 1'b1;
		dly <= 4'h2;
		@(posedge clk_in);
		susp_req <= 1'b0;
		plug <= 1'b1;
		@(posedge clk_in);
		plug <= 1'b0;
		watch(30, s);
		chk({31'h0, s}, 32'h0);
		chk({31'h0, suspended}, 32'h1);
		wr(OFS_HUB_STATE, 32'h0000_8000);
		rd_chk(OFS_HUB_STATE, 32'h0000_8000);
		plug <= 1'b1;
		dly <= 4'hc;
		@(posedge clk_in);
		plug <= 1'b0;
		watch(40, s);
		chk({31'h0, s}, 32'h1);
		repeat (5) @(posedge clk_in);
		chk({31'h0, suspended}, 32'h0);
		wr(OFS_HUB_STATE, 32'h8000_8000);
		rd_chk(OFS_HUB_STATE, 32'h0);
		$display("wake test done");
	endtask

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#(40 * 40000);
		error_cnt++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		test_reset();
		test_desc();
		test_frame();
		test_wake();
		complete_run();
	end
endmodule
